// *** design/smr_device.sv ***
// Device end: base mode register, burst ordering and DLL reset
`timescale 1ns/1ps
`include "smr_consts.svh"
// Functional notes
// - Two-bit field picks BL8, BC4 or on-the-fly
// - On-the-fly: A12 low chop, high eight
// - Burst wraps within aligned column block
// - Burst length applies to reads and writes
// - Controller writes zero to reserved bits
// - Bit 3 selects sequential or interleaved
// - Sequential: rotate within nibble, then other
// - Interleaved: beat column is start xor k
// - Chop read: four beats then tri-state
// - Chop write: nibble from bit 2, ascending
// - Eight write: columns 0..7 ascending always
// - Chop bursts start same cycle as eight
// - DLL reset bit self-clears after start
// - Controller waits 514 cycles before read
// - Bits 11:9 set write recovery cycles
// - Controller programs rounded-up write recovery
// - Bit 12 low: DLL off, slow exit
// - Bit 12 high: DLL on, fast exit
// - Bits 6:4 hold read latency 4..11
// - Mode set only when idle, then wait
module smr_device
(
   input  wire logic  ref_clk,          // Clock
   input  wire logic  rst,              // Synchronous reset, active high
   smr_if.dev         lnk,              // Command link
   output logic [18:0] mode_q,          // Stored base mode register
   output logic [3:0]  wr_recovery_q,   // Decoded write recovery cycles
   output logic [3:0]  read_latency_q,  // Decoded read latency cycles
   output logic        dll_running_q,   // DLL running
   output logic        wr_code_bad_q,   // Unsupported write recovery code
   output logic [2:0]  wr_col_q,        // Column written on last taken beat
   output logic [7:0]  wr_data_q        // Data written on last taken beat
);
   logic [7:0]  mem_q [0:7];
   logic [2:0]  start_q;
   logic [3:0]  beat_q;
   logic        active_q;
   logic        is_read_q;
   logic        chop_q;
   logic        order_q;
   logic [9:0]  dll_cnt_q;
   logic        pd_q;
   logic        chop_d;
   logic [2:0]  col_d;

   // Burst length chosen per command or by the fixed field
   always_comb
   begin
      case (mode_q[`SMR_BL_MSB:`SMR_BL_LSB])
         `SMR_BL_OTF:   chop_d = ~lnk.addr[`SMR_OTF_BIT];
         `SMR_BL_CHOP4: chop_d = 1'b1;
         default:       chop_d = 1'b0;
      endcase
   end

   // Beat column: reads wrap in block by order, writes ignore the low bits
   always_comb
   begin
      if (!is_read_q)
         col_d = chop_q ? {start_q[2], beat_q[1:0]} : beat_q[2:0];
      else if (order_q)
         col_d = start_q ^ beat_q[2:0];
      else
         col_d = {start_q[2] ^ beat_q[2], start_q[1:0] + beat_q[1:0]};
   end

   // Mode capture; reserved bits stored as given, the controller keeps them zero
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         mode_q <= `SMR_MODE_RESET;
      else if (lnk.cke && lnk.cmd == smr_pkg::CMD_MRS && lnk.bank == 3'h0)
         mode_q <= lnk.addr;
      else if (mode_q[`SMR_DLLRST_BIT])
         mode_q[`SMR_DLLRST_BIT] <= 1'b0;
   end

   // DLL lock counter restarts on each reset of the DLL
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         dll_cnt_q <= 10'h000;
      else if (mode_q[`SMR_DLLRST_BIT])
         dll_cnt_q <= `SMR_DLLK_CYCLES;
      else if (dll_cnt_q != 10'h000 && lnk.cke)
         dll_cnt_q <= dll_cnt_q - 10'h001;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         lnk.dll_locked <= 1'b0;
      else
         lnk.dll_locked <= (dll_cnt_q == 10'h000) && !mode_q[`SMR_DLLRST_BIT];
   end

   // Precharge power-down: DLL stops only when bit 12 is low
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         pd_q <= 1'b0;
      else if (lnk.cmd == smr_pkg::CMD_PDE)
         pd_q <= 1'b1;
      else if (lnk.cmd == smr_pkg::CMD_PDX)
         pd_q <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         dll_running_q <= 1'b0;
      else
         dll_running_q <= !(pd_q && !mode_q[`SMR_PPD_BIT]);
   end

   // Field decode
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         wr_recovery_q  <= 4'h0;
         wr_code_bad_q  <= 1'b0;
         read_latency_q <= 4'h0;
      end
      else
      begin
         case (mode_q[`SMR_WR_MSB:`SMR_WR_LSB])
            3'h1:    wr_recovery_q <= 4'h5;
            3'h2:    wr_recovery_q <= 4'h6;
            3'h3:    wr_recovery_q <= 4'h7;
            3'h4:    wr_recovery_q <= 4'h8;
            3'h5:    wr_recovery_q <= 4'hA;
            3'h6:    wr_recovery_q <= 4'hC;
            default: wr_recovery_q <= 4'h0;
         endcase
         wr_code_bad_q  <= (mode_q[`SMR_WR_MSB:`SMR_WR_LSB] == 3'h0)
                           || (mode_q[`SMR_WR_MSB:`SMR_WR_LSB] == 3'h7);
         read_latency_q <= {1'b0, mode_q[`SMR_CL_MSB:`SMR_CL_LSB]} + 4'h4;
      end
   end

   // Burst sequencer always runs eight slots, chop or not
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         active_q  <= 1'b0;
         beat_q    <= 4'h0;
         start_q   <= 3'h0;
         is_read_q <= 1'b0;
         chop_q    <= 1'b0;
         order_q   <= 1'b0;
      end
      else if (!active_q && lnk.cke && (lnk.cmd == smr_pkg::CMD_READ || lnk.cmd == smr_pkg::CMD_WRITE))
      begin
         active_q  <= 1'b1;
         beat_q    <= 4'h0;
         start_q   <= lnk.addr[2:0];
         is_read_q <= (lnk.cmd == smr_pkg::CMD_READ);
         chop_q    <= chop_d;
         order_q   <= mode_q[`SMR_BT_BIT];
      end
      else if (active_q)
      begin
         beat_q   <= beat_q + 4'h1;
         active_q <= (beat_q != 4'h7);
      end
   end

   // Beat outputs; chop reads go tri-state after four beats
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         lnk.rdata      <= 8'h00;
         lnk.rdata_oe   <= 1'b0;
         lnk.strobe_oe  <= 1'b0;
         lnk.beat_col   <= 3'h0;
         lnk.wbeat_take <= 1'b0;
      end
      else
      begin
         lnk.rdata_oe   <= active_q && is_read_q && !(chop_q && beat_q[2]);
         lnk.strobe_oe  <= active_q && is_read_q && !(chop_q && beat_q[2]);
         lnk.rdata      <= mem_q[col_d];
         lnk.beat_col   <= col_d;
         lnk.wbeat_take <= active_q && !is_read_q && !(chop_q && beat_q[2]);
      end
   end

   // Write data store; chop writes drop the last four slots
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         wr_col_q  <= 3'h0;
         wr_data_q <= 8'h00;
      end
      else if (active_q && !is_read_q && !(chop_q && beat_q[2]))
      begin
         mem_q[col_d] <= lnk.wdata;
         wr_col_q     <= col_d;
         wr_data_q    <= lnk.wdata;
      end
   end
endmodule : smr_device

// *** common/smr_consts.svh ***
// Constants for the base mode register burst logic
`ifndef SMR_CONSTS_SVH
`define SMR_CONSTS_SVH
`define SMR_BL_LSB        0
`define SMR_BL_MSB        1
`define SMR_BT_BIT        3
`define SMR_CL_LSB        4
`define SMR_CL_MSB        6
`define SMR_DLLRST_BIT    8
`define SMR_WR_LSB        9
`define SMR_WR_MSB        11
`define SMR_PPD_BIT       12
`define SMR_OTF_BIT       12
`define SMR_BL_FIXED8     2'h0
`define SMR_BL_OTF        2'h1
`define SMR_BL_CHOP4      2'h2
`define SMR_RESERVED_MASK 19'h4E080
`define SMR_MODE_RESET    19'h00000
`define SMR_DLLK_CYCLES   10'h200
`define SMR_XP_NS         6
`define SMR_XPDLL_NS      24
`define SMR_CLK_NS        8
`define SMR_XP_CYCLES     (((`SMR_XP_NS) + (`SMR_CLK_NS) - 1) / (`SMR_CLK_NS))
`define SMR_XPDLL_CYCLES  (((`SMR_XPDLL_NS) + (`SMR_CLK_NS) - 1) / (`SMR_CLK_NS))
`define SMR_MRD_CYCLES    4'h4
`endif

// *** common/smr_pkg.sv ***
// Types shared by both ends of the mode register link
package smr_pkg;
   typedef enum logic [2:0] {CMD_NOP, CMD_MRS, CMD_READ, CMD_WRITE, CMD_PDE, CMD_PDX} smr_cmd_type;
   typedef logic [18:0] smr_addr_type;
endpackage : smr_pkg

// *** common/smr_if.sv ***
// Command link between controller and memory device
`timescale 1ns/1ps
interface smr_if;
   smr_pkg::smr_cmd_type  cmd;          // Command code
   logic [2:0]            bank;         // Bank address
   smr_pkg::smr_addr_type addr;         // Address bus
   logic                  cke;          // Clock enable
   logic [7:0]            wdata;        // Write beat data
   logic [7:0]            rdata;        // Read beat data
   logic                  rdata_oe;     // Read data drive enable
   logic                  strobe_oe;    // Strobe drive enable
   logic [2:0]            beat_col;     // Column of current beat
   logic                  wbeat_take;   // Device stores current write beat
   logic                  dll_locked;   // DLL lock reached
   modport dev  (input cmd, bank, addr, cke, wdata,
                 output rdata, rdata_oe, strobe_oe, beat_col, wbeat_take, dll_locked);
   modport ctrl (output cmd, bank, addr, cke, wdata,
                 input rdata, rdata_oe, strobe_oe, beat_col, wbeat_take, dll_locked);
endinterface : smr_if

// *** design/smr_ctrl.sv ***
// Controller end: issues mode sets, reads, writes and power-down
`timescale 1ns/1ps
`include "smr_consts.svh"
module smr_ctrl
(
   input  wire logic  ref_clk,          // Clock
   input  wire logic  rst,              // Synchronous reset, active high
   smr_if.ctrl        lnk,              // Command link
   input  wire logic [3:0]  req_addr,   // Register address
   input  wire logic [31:0] req_wdata,  // Register write data
   input  wire logic        req_wr,     // Write strobe
   input  wire logic        req_rd,     // Read strobe
   output logic [31:0]      req_rdata_q // Read data, one cycle after strobe
);
   // 0: mode value, also column and A12 (bit 16) for READ and WRITE, 1: command go (write code), 2: status, 3: write data
   logic [18:0] mode_val_q;
   logic [18:0] col_addr;
   logic        ppd_q;
   logic [7:0]  wdata_q;
   logic [9:0]  lock_q;
   logic [3:0]  wait_q;
   logic        pdn_q;
   logic [7:0]  last_rd_q;

   // The code field overlaps the low bits of the command write, so the column comes from register 0
   assign col_addr = {4'h0, mode_val_q[14:13], mode_val_q[16], mode_val_q[11:0]};

   // Read is held off during lock wait, exit delay and mode spacing
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         lnk.cmd  <= smr_pkg::CMD_NOP;
         lnk.bank <= 3'h0;
         lnk.addr <= 19'h00000;
         lnk.cke  <= 1'b1;
         lnk.wdata <= 8'h00;
         lock_q   <= 10'h000;
         wait_q   <= 4'h0;
         pdn_q    <= 1'b0;
         ppd_q    <= 1'b0;
      end
      else
      begin
         lnk.cmd   <= smr_pkg::CMD_NOP;
         lnk.wdata <= wdata_q;
         if (lock_q != 10'h000)
            lock_q <= lock_q - 10'h001;
         if (wait_q != 4'h0)
            wait_q <= wait_q - 4'h1;
         if (req_wr && req_addr == 4'h1 && wait_q == 4'h0)
         begin
            case (req_wdata[2:0])
               3'h1:
               begin
                  lnk.cmd  <= smr_pkg::CMD_MRS;
                  lnk.bank <= 3'h0;
                  lnk.addr <= mode_val_q & ~`SMR_RESERVED_MASK;
                  wait_q   <= `SMR_MRD_CYCLES;
                  ppd_q    <= mode_val_q[`SMR_PPD_BIT];
                  if (mode_val_q[`SMR_DLLRST_BIT])
                     lock_q <= `SMR_DLLK_CYCLES + 10'h002;
               end
               3'h2:
               begin
                  if (lock_q == 10'h000 && !pdn_q)
                  begin
                     lnk.cmd  <= smr_pkg::CMD_READ;
                     lnk.addr <= col_addr;
                     wait_q   <= 4'h9;
                  end
               end
               3'h3:
               begin
                  if (!pdn_q)
                  begin
                     lnk.cmd  <= smr_pkg::CMD_WRITE;
                     lnk.addr <= col_addr;
                     wait_q   <= 4'h9;
                  end
               end
               3'h4:
               begin
                  lnk.cmd <= smr_pkg::CMD_PDE;
                  pdn_q   <= 1'b1;
               end
               3'h5:
               begin
                  lnk.cmd <= smr_pkg::CMD_PDX;
                  pdn_q   <= 1'b0;
                  // Exit delay follows the power-down bit last sent, not the operand register
                  wait_q  <= ppd_q ? 4'(`SMR_XP_CYCLES) : 4'(`SMR_XPDLL_CYCLES);
               end
               default:
               begin
               end
            endcase
         end
      end
   end

   // Write recovery field is computed by software as ceil(tWR/tCK)
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         mode_val_q <= `SMR_MODE_RESET;
         wdata_q    <= 8'h00;
      end
      else if (req_wr && req_addr == 4'h0)
         mode_val_q <= req_wdata[18:0];
      else if (req_wr && req_addr == 4'h3)
         wdata_q <= req_wdata[7:0];
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         last_rd_q <= 8'h00;
      else if (lnk.rdata_oe)
         last_rd_q <= lnk.rdata;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         req_rdata_q <= 32'h00000000;
      else if (req_rd)
      begin
         case (req_addr)
            4'h0:    req_rdata_q <= {13'h0000, mode_val_q};
            4'h2:    req_rdata_q <= {16'h0000, lnk.dll_locked, pdn_q, (lock_q == 10'h000), (wait_q == 4'h0), last_rd_q, 4'h0};
            4'h3:    req_rdata_q <= {24'h000000, wdata_q};
            default: req_rdata_q <= 32'h00000000;
         endcase
      end
      else
         req_rdata_q <= 32'h00000000;
   end
endmodule : smr_ctrl

// *** tb/smr_checker_sva.sv ***
// Concurrent checks on the command link between controller and device
`timescale 1ns/1ps
`include "smr_consts.svh"
module smr_checker
(
   input wire logic            ref_clk,    // Clock
   input wire logic            rst,        // Reset
   input smr_pkg::smr_cmd_type  cmd,        // Command
   input wire logic [2:0]      bank,       // Bank address
   input smr_pkg::smr_addr_type addr,       // Address bus
   input wire logic            cke,        // Clock enable
   input wire logic            rdata_oe,   // Read drive
   input wire logic            strobe_oe,  // Strobe drive
   input wire logic [2:0]      beat_col,   // Beat column
   input wire logic            wbeat_take, // Write beat stored
   input wire logic            dll_locked  // Lock reached
);
   logic [18:0] mode_h_q;
   logic [9:0]  lock_cnt_q;
   logic        chop;
   logic        nib;
   logic [2:0]  start_col;
   logic        is_rd;
   logic        is_wr;
   assign chop      = mode_h_q[1:0] == `SMR_BL_CHOP4 || (mode_h_q[1:0] == `SMR_BL_OTF && !addr[12]);
   assign start_col = addr[2:0];
   assign nib       = addr[2];
   assign is_rd     = cmd == smr_pkg::CMD_READ;
   assign is_wr     = cmd == smr_pkg::CMD_WRITE;
   always_ff @(posedge ref_clk)
      if (rst)
         mode_h_q <= 19'h00000;
      else if (cke && cmd == smr_pkg::CMD_MRS && bank == 3'h0)
         mode_h_q <= addr;
   // Saturates so a lock long after reset cannot wrap into a false early count
   always_ff @(posedge ref_clk)
      if (rst)
         lock_cnt_q <= 10'h3FF;
      else if (cmd == smr_pkg::CMD_MRS && bank == 3'h0 && addr[8])
         lock_cnt_q <= 10'h000;
      else if (cke && lock_cnt_q != 10'h3FF)
         lock_cnt_q <= lock_cnt_q + 10'h001;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence oe_four;
      (rdata_oe && strobe_oe) [*4];
   endsequence
   reserved_zero_a: assert property (cmd == smr_pkg::CMD_MRS |-> (addr & `SMR_RESERVED_MASK) == 19'h00000)
      else $error("reserved mode bits sent");
   read_start_a: assert property (is_rd |-> ##2 beat_col == $past(start_col, 2))
      else $error("first read beat column wrong");
   read_chop_a: assert property (is_rd && chop |-> ##2 oe_four ##1 (!rdata_oe && !strobe_oe) [*4])
      else $error("chopped read drive window wrong");
   read_eight_a: assert property (is_rd && !chop |-> ##2 oe_four ##1 oe_four)
      else $error("eight beat read drive window wrong");
   write_eight_a: assert property (is_wr && !chop |-> ##2 (wbeat_take && beat_col == 3'h0) ##1
      (wbeat_take && beat_col == 3'h1) ##6 (wbeat_take && beat_col == 3'h7))
      else $error("eight beat write columns wrong");
   write_chop_a: assert property (is_wr && chop |-> ##2 (wbeat_take && beat_col == {$past(nib, 2), 2'h0})
      ##3 (wbeat_take && beat_col[1:0] == 2'h3) ##1 (!wbeat_take) [*4])
      else $error("chopped write beats wrong");
   read_locked_a: assert property (is_rd |-> dll_locked)
      else $error("read issued before lock");
   lock_early_a: assert property ($rose(dll_locked) |-> lock_cnt_q >= 10'h1FF)
      else $error("lock reported too early");
   lock_late_a: assert property (lock_cnt_q == 10'h220 |-> dll_locked)
      else $error("lock not reported in time");
   slow_exit_a: assert property (cmd == smr_pkg::CMD_PDX && !mode_h_q[12] |-> ##1 (cmd == smr_pkg::CMD_NOP) [*2])
      else $error("command too soon after slow exit");
   fast_exit_c: cover property (cmd == smr_pkg::CMD_PDX && mode_h_q[12]);
endmodule : smr_checker

// *** tb/sdram_mode_reg0_burst_logic_tb.sv ***
// Bench joining controller and device ends over the command link
`timescale 1ns/1ps
`include "smr_consts.svh"
module sdram_mode_reg0_burst_logic_tb;
   localparam logic [3:0] WRT [8] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC, 4'h0};
   logic        ref_clk, rst, req_wr, req_rd, dll_running_q, wr_code_bad_q;
   logic [3:0]  req_addr, wr_recovery_q, read_latency_q;
   logic [31:0] req_wdata, req_rdata_q, lfsr, ra;
   logic [18:0] mode_q, mval;
   logic [2:0]  wr_col_q, s;
   logic [7:0]  wr_data_q;
   logic [10:0] exp_q[$];
   logic [10:0] e;
   logic [7:0]  mdl [8];
   logic [2:0]  c;
   int          fail_count, n_compared, cycles, nb;
   smr_if lnk ();
   smr_device smr_device_i (.ref_clk(ref_clk), .rst(rst), .lnk(lnk), .mode_q(mode_q), .wr_recovery_q(wr_recovery_q),
      .read_latency_q(read_latency_q), .dll_running_q(dll_running_q), .wr_code_bad_q(wr_code_bad_q),
      .wr_col_q(wr_col_q), .wr_data_q(wr_data_q));
   smr_ctrl smr_ctrl_i (.ref_clk(ref_clk), .rst(rst), .lnk(lnk), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_wr(req_wr), .req_rd(req_rd), .req_rdata_q(req_rdata_q));
   smr_checker smr_checker_i (.ref_clk(ref_clk), .rst(rst), .cmd(lnk.cmd), .bank(lnk.bank), .addr(lnk.addr),
      .cke(lnk.cke), .rdata_oe(lnk.rdata_oe), .strobe_oe(lnk.strobe_oe), .beat_col(lnk.beat_col),
      .wbeat_take(lnk.wbeat_take), .dll_locked(lnk.dll_locked));
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   function automatic logic [2:0] rd_col(input logic [2:0] st, input logic [2:0] k, input logic bt);
      return bt ? st ^ k : {st[2] ^ k[2], st[1:0] + k[1:0]};
   endfunction : rd_col
   task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask : cmp
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      req_addr  <= a;
      req_wdata <= d;
      req_wr    <= 1'b1;
      @(posedge ref_clk);
      req_wr    <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      req_addr <= a;
      req_rd   <= 1'b1;
      @(posedge ref_clk);
      req_rd   <= 1'b0;
      @(negedge ref_clk);
      d = req_rdata_q;
   endtask : reg_rd
   // Long enough for the spacing counter and a full eight slot burst
   task automatic issue(input logic [2:0] code, input logic [31:0] a);
      reg_wr(4'h0, a);
      reg_wr(4'h1, {29'h0, code});
      repeat (16) @(posedge ref_clk);
   endtask : issue
   task automatic stop_test;
      if (fail_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fail_count++;
         stop_test();
      end
      if (lnk.rdata_oe === 1'b1 || lnk.wbeat_take === 1'b1)
         if (exp_q.size() == 0)
            cmp("beat_count", 32'h0, 32'h1);
         else
         begin
            e = exp_q.pop_front();
            cmp("beat_col", 32'(e[2:0]), 32'(lnk.beat_col));
            cmp("beat_data", 32'(e[10:3]), 32'(lnk.rdata_oe === 1'b1 ? lnk.rdata : wr_data_q));
         end
   end
   initial
   begin
      rst = 1'b1;
      req_wr = 1'b0;
      req_rd = 1'b0;
      req_addr = 4'h0;
      req_wdata = 32'h0;
      lfsr = 32'h8A05;
      repeat (3) @(posedge ref_clk);
      cmp("mode_q", 32'h0, 32'(mode_q));
      cmp("dll_locked", 32'h0, 32'(lnk.dll_locked));
      rst <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         mval = {7'h0, 3'(i), 1'b1, 1'b0, 3'(i), 4'h0} | `SMR_RESERVED_MASK;
         issue(3'h1, {13'h0, mval});
         cmp("mode_q", 32'(mval & ~`SMR_RESERVED_MASK & 19'h7FEFF), 32'(mode_q));
         cmp("wr_recovery", 32'(WRT[i]), 32'(wr_recovery_q));
         cmp("wr_code_bad", 32'(i == 0 || i == 7), 32'(wr_code_bad_q));
         cmp("read_latency", 32'(i + 4), 32'(read_latency_q));
      end
      for (int n = 0; n < 700 && lnk.dll_locked !== 1'b1; n++)
         @(posedge ref_clk);
      cmp("dll_locked", 32'h1, 32'(lnk.dll_locked));
      reg_rd(4'hF, ra);
      cmp("unmapped_read", 32'h0, ra);
      reg_rd(4'h2, ra);
      cmp("status", 32'h0000B000, ra);
      for (int v = 0; v < 8; v++)
      begin
         mval = {6'h0, v[1], 3'h2, 2'h0, 3'h2, v[0], 1'b0, v[2:1] == 2'h3 ? 2'h2 : (v[2:1] == 2'h0 ? 2'h0 : 2'h1)};
         issue(3'h1, {13'h0, mval});
         issue(3'h4, 32'h0);
         cmp("dll_running", 32'(v[1]), 32'(dll_running_q));
         issue(3'h5, 32'h0);
         lfsr = lfsr_next(lfsr);
         s = lfsr[2:0];
         nb = (v[2:1] == 2'h3 || v[2:1] == 2'h1) ? 4 : 8;
         ra = {15'h0, v[2:1] == 2'h2, 3'h0, v[2:1] == 2'h2, 9'h0, s};
         // Write first so every column read back holds known data
         reg_wr(4'h3, lfsr);
         for (int k = 0; k < nb; k++)
         begin
            c = (nb == 4) ? {s[2], 2'(k)} : 3'(k);
            mdl[c] = lfsr[7:0];
            exp_q.push_back({lfsr[7:0], c});
         end
         issue(3'h3, ra);
         cmp("wr_col", 32'(nb == 4 ? {s[2], 2'h3} : 3'h7), 32'(wr_col_q));
         cmp("wr_data", 32'(lfsr[7:0]), 32'(wr_data_q));
         for (int k = 0; k < nb; k++)
         begin
            c = rd_col(s, 3'(k), v[0]);
            exp_q.push_back({mdl[c], c});
         end
         issue(3'h2, ra);
      end
      cmp("pending", 32'h0, 32'(exp_q.size()));
      stop_test();
   end
endmodule : sdram_mode_reg0_burst_logic_tb
